/* File: inc/dpid_pkg.sv */
// Shared constants and types for the defect pad and sector ident link
package dpid_pkg;

  // ----------------------------------------------------------------
  // Link geometry
  // ----------------------------------------------------------------
  localparam int PAR_W = 16;
  localparam int IDENT_W = 64;
  localparam int HEADS = 8;
  localparam int IDENT_PARCELS = 4;
  localparam int DATA_PARCELS = 8192;
  localparam int PAD_PARCELS = 72;
  localparam int FIFO_DEPTH = 8;
  localparam int PC_W = 14;

  // ----------------------------------------------------------------
  // Ident field positions (lsb) and limits
  // ----------------------------------------------------------------
  localparam int DEFH_POS = 0;
  localparam int CYL_POS = 8;
  localparam int WLOCK_POS = 20;
  localparam int RLOCK_POS = 21;
  localparam int HEAD_POS = 22;
  localparam int SECT_POS = 24;
  localparam int KHF_POS = 29;
  localparam int UHF_POS = 30;
  localparam int IFF_POS = 31;
  localparam int DEF_POS = 32;
  localparam logic [11:0] CYL_MAX = 12'hA32;
  localparam logic [4:0] SECT_MAX = 5'h16;
  localparam logic [11:0] DEF_MAX = 12'h804;
  localparam logic [11:0] DEF_NO_PAD = 12'h804;

  // ----------------------------------------------------------------
  // Operations and adapter states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    OP_IDENT_WR = 2'h0,
    OP_IDENT_RD = 2'h1,
    OP_DATA_WR = 2'h2,
    OP_DATA_RD = 2'h3
  } dpid_op_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_IDW = 3'h1,
    ST_IDR = 3'h2,
    ST_DW = 3'h3,
    ST_DR = 3'h4
  } dpid_state_t;

endpackage

/* File: inc/dpid_link_if.sv */
// Parcel link between channel adapter and parallel-head drive
`timescale 1ns/1ps
`default_nettype none
interface dpid_link_if (
  input wire logic sys_clk,
  input wire logic rst_n
);
  import dpid_pkg::*;
  logic gate;
  dpid_op_t op;
  logic old_variant;
  logic [PAR_W-1:0] a2d_par;
  logic a2d_vld;
  logic d2a_rdy;
  logic [PAR_W-1:0] d2a_par;
  logic d2a_vld;

  modport adapter (
    output gate, op, old_variant, a2d_par, a2d_vld,
    input d2a_rdy, d2a_par, d2a_vld
  );
  modport drive (
    input gate, op, old_variant, a2d_par, a2d_vld,
    output d2a_rdy, d2a_par, d2a_vld
  );
endinterface
`default_nettype wire

/* File: rtl/dpid_drive.sv */
// Drive end: spreads ident and data bytes over the heads of a group
`timescale 1ns/1ps
`default_nettype none
module dpid_drive
  import dpid_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Link
  dpid_link_if.drive lnk,
  // Head group side
  input wire logic phys_ready,
  output logic [IDENT_W-1:0] phys_word_q,
  output logic [HEADS-1:0] phys_parity_q,
  output logic phys_stb_q,
  input wire logic [PAR_W-1:0] media_par,
  input wire logic media_vld,
  output logic [IDENT_W+HEADS-1:0] ident_fields_q
);

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  logic [IDENT_W-1:0] acc_q;
  logic [1:0] cnt_q;
  logic [2:0] rd_cnt_q;
  logic rdy_q;
  logic [PAR_W-1:0] par_q;
  logic vld_q;
  logic [IDENT_W-1:0] acc_next;
  logic [IDENT_W-1:0] spread;
  logic [IDENT_W-1:0] gather;
  logic [HEADS-1:0] odd_par;
  logic take;
  logic last;
  logic in_idw;
  logic in_idr;
  logic in_dw;
  logic in_dr;
  logic [5:0] rd_sel;

  assign in_idw = lnk.gate && (lnk.op == OP_IDENT_WR);
  assign in_idr = lnk.gate && (lnk.op == OP_IDENT_RD);
  assign in_dw = lnk.gate && (lnk.op == OP_DATA_WR);
  assign in_dr = lnk.gate && (lnk.op == OP_DATA_RD);
  assign take = lnk.a2d_vld && rdy_q;
  assign last = take && (cnt_q == 2'h3);
  // Lower byte of a pair rides in the upper half of the parcel
  assign acc_next = {lnk.a2d_par[7:0], lnk.a2d_par[15:8], acc_q[IDENT_W-1:16]};
  assign rd_sel = {rd_cnt_q[1:0], 4'h0};

  // ----------------------------------------------------------------
  // Bit h of every byte lands under head h
  // ----------------------------------------------------------------
  for (genvar h = 0; h < HEADS; h++) begin : g_head
    for (genvar k = 0; k < HEADS; k++) begin : g_byte
      assign spread[8*h+k] = acc_next[8*k+h];
      assign gather[8*k+h] = ident_fields_q[8*h+k];
    end
    // Odd parity of byte h for the ninth head in the older variant; zero in the newer one
    assign odd_par[h] = lnk.old_variant & ~(^acc_next[8*h +: 8]);
  end

  // ----------------------------------------------------------------
  // Parcel accumulation and head fields
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_q <= '0;
      cnt_q <= 2'h0;
      rdy_q <= 1'b0;
      ident_fields_q <= '0;
      phys_word_q <= '0;
      phys_parity_q <= '0;
      phys_stb_q <= 1'b0;
    end else begin
      // In data writes ready lags phys_ready by one cycle, so stalls reach the adapter; ident writes are always ready
      rdy_q <= in_idw || (in_dw && phys_ready);
      phys_stb_q <= in_dw && last;
      if (!lnk.gate) begin
        cnt_q <= 2'h0;
      end else if (take) begin
        acc_q <= acc_next;
        cnt_q <= cnt_q + 2'h1;
      end
      if (in_idw && last) begin
        ident_fields_q <= {odd_par, spread};
      end
      if (in_dw && last) begin
        phys_word_q <= spread;
        phys_parity_q <= odd_par;
      end
    end
  end

  // ----------------------------------------------------------------
  // Return path: ident replay or media parcels
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_cnt_q <= 3'h0;
      par_q <= '0;
      vld_q <= 1'b0;
    end else begin
      if (in_idr && (rd_cnt_q < 3'h4)) begin
        par_q <= {gather[rd_sel +: 8], gather[rd_sel + 6'h08 +: 8]};
        vld_q <= 1'b1;
        rd_cnt_q <= rd_cnt_q + 3'h1;
      end else if (in_dr) begin
        par_q <= media_par;
        vld_q <= media_vld;
      end else begin
        vld_q <= 1'b0;
      end
      if (!lnk.gate) begin
        rd_cnt_q <= 3'h0;
      end
    end
  end

  assign lnk.d2a_rdy = rdy_q;
  assign lnk.d2a_par = par_q;
  assign lnk.d2a_vld = vld_q;

endmodule
`default_nettype wire

/* File: rtl/dpid_adapter.sv */
// Adapter end: ident transfer and decode, defect pad insertion
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------------
// Write data buffer
// ------------------------------------------------------------------
module dpid_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Fill side
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  // Drain side
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic [AW:0] cnt_d;
  logic full_q;
  logic push;
  logic pop;

  // Depth must be a power of two so the pointers wrap by themselves
  assign push = in_valid && !full_q;
  assign pop = out_valid && out_ready;
  assign cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  assign in_ready = !full_q;
  assign out_valid = cnt_q != '0;
  assign out_data = mem_q[rd_q];

  // Storage needs no reset
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  // Pointers and occupancy
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      full_q <= 1'b0;
    end else begin
      wr_q <= wr_q + AW'(push);
      rd_q <= rd_q + AW'(pop);
      cnt_q <= cnt_d;
      full_q <= cnt_d == (AW+1)'(DEPTH);
    end
  end
endmodule

module dpid_adapter
  import dpid_pkg::*;
#(
  parameter int DATA_LEN = DATA_PARCELS,
  parameter int PAD_LEN = PAD_PARCELS,
  parameter int BUF_DEPTH = FIFO_DEPTH
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Command
  input wire logic cmd_go,
  input wire dpid_op_t cmd_op,
  input wire logic [IDENT_W-1:0] cmd_ident,
  input wire logic old_variant,
  input wire logic wr_lock_ovr,
  input wire logic rd_lock_ovr,
  // Write data from buffer board
  input wire logic [PAR_W-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  // Read data to buffer board
  output logic [PAR_W-1:0] rd_par_q,
  output logic rd_vld_q,
  // Status
  output logic busy_q,
  output logic done_q,
  output logic lock_err_q,
  output logic range_err_q,
  output logic padding_q,
  output logic [IDENT_W-1:0] ident_q,
  // Link
  dpid_link_if.adapter lnk
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  dpid_state_t state_q;
  dpid_op_t op_q;
  logic gate_q;
  logic oldv_q;
  logic [PAR_W-1:0] par_q;
  logic vld_q;
  logic [IDENT_W-1:0] sh_q;
  logic [2:0] cnt_q;
  logic [PC_W-1:0] pc_q;
  logic [6:0] pad_cnt_q;
  logic pad_done_q;
  logic [PAR_W-1:0] last_par_q;
  logic [PAR_W-1:0] f_data;
  logic f_valid;
  logic f_ready;

  // ----------------------------------------------------------------
  // Decoded ident fields
  // ----------------------------------------------------------------
  logic [7:0] defect_head;
  logic [11:0] cyl_addr;
  logic write_lock_flag;
  logic read_lock_flag;
  logic head_addr;
  logic [4:0] sector_addr;
  logic known_hideable_flag;
  logic unhideable_flag;
  logic ident_field_flaw_flag;
  logic [11:0] defect_param;
  logic bad_range;

  assign defect_head = ident_q[DEFH_POS +: 8];
  assign cyl_addr = ident_q[CYL_POS +: 12];
  assign write_lock_flag = ident_q[WLOCK_POS];
  assign read_lock_flag = ident_q[RLOCK_POS];
  assign head_addr = ident_q[HEAD_POS];
  assign sector_addr = ident_q[SECT_POS +: 5];
  assign known_hideable_flag = ident_q[KHF_POS];
  assign unhideable_flag = ident_q[UHF_POS];
  assign ident_field_flaw_flag = ident_q[IFF_POS];
  assign defect_param = ident_q[DEF_POS +: 12];
  // Head field is one bit, so only cylinder, sector and parameter can overflow
  assign bad_range = (cyl_addr > CYL_MAX) || (sector_addr > SECT_MAX)
    || (defect_param > DEF_MAX);

  // ----------------------------------------------------------------
  // Sequencing terms
  // ----------------------------------------------------------------
  logic slot;
  logic sent;
  logic wr_block;
  logic rd_block;
  logic no_pad;
  logic in_pad;
  logic pad_start;
  logic rep_go;
  logic data_go;
  logic idw_go;
  logic rx;
  logic [PC_W-1:0] rd_total;
  logic [PAR_W-1:0] rep_par;
  logic [PAR_W-1:0] next_par;

  assign slot = !vld_q || lnk.d2a_rdy;
  assign sent = vld_q && lnk.d2a_rdy;
  assign wr_block = write_lock_flag && !wr_lock_ovr;
  assign rd_block = read_lock_flag && !rd_lock_ovr;
  assign no_pad = defect_param == DEF_NO_PAD;
  assign in_pad = pad_cnt_q != 7'h00;
  // Word count drops the two low counter bits; one word is one head byte
  // A start point at or past the sector end never pads
  assign pad_start = (state_q == ST_DW) && slot && !in_pad && !pad_done_q
    && !no_pad && (pc_q[1:0] == 2'h0) && (pc_q < PC_W'(DATA_LEN))
    && (pc_q[PC_W-1:2] == defect_param);
  // Older variant repeats the last parcel sent, newer one peeks the next
  assign rep_par = oldv_q ? last_par_q : f_data;
  assign rep_go = (state_q == ST_DW) && slot && in_pad && (oldv_q || f_valid);
  assign data_go = (state_q == ST_DW) && slot && !in_pad && !pad_start
    && (pc_q < PC_W'(DATA_LEN)) && f_valid;
  assign idw_go = (state_q == ST_IDW) && slot && (cnt_q < 3'h4);
  assign f_ready = data_go;
  assign rx = lnk.d2a_vld;
  // Read length covers the pad whenever the parameter is not DEF_NO_PAD
  assign rd_total = no_pad ? PC_W'(DATA_LEN) : PC_W'(DATA_LEN + PAD_LEN);
  assign next_par = idw_go ? {sh_q[7:0], sh_q[15:8]}
    : (rep_go ? rep_par : f_data);

  // ----------------------------------------------------------------
  // Write buffer
  // ----------------------------------------------------------------
  dpid_fifo #(
    .WIDTH(PAR_W),
    .DEPTH(BUF_DEPTH)
  ) u_fifo (
    .clk(sys_clk),
    .rst_n(rst_n),
    .in_data(in_data),
    .in_valid(in_valid),
    .in_ready(in_ready),
    .out_data(f_data),
    .out_valid(f_valid),
    .out_ready(f_ready)
  );

  // ----------------------------------------------------------------
  // Link output register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      par_q <= '0;
      vld_q <= 1'b0;
    end else if (idw_go || rep_go || data_go) begin
      par_q <= next_par;
      vld_q <= 1'b1;
    end else if (sent) begin
      vld_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Parcel and defect counters
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pc_q <= '0;
      pad_cnt_q <= 7'h00;
      pad_done_q <= 1'b0;
      last_par_q <= '0;
    end else if (state_q == ST_IDLE) begin
      pc_q <= '0;
      pad_cnt_q <= 7'h00;
      pad_done_q <= 1'b0;
      last_par_q <= '0;
    end else begin
      if (pad_start) begin
        pad_cnt_q <= 7'(PAD_LEN);
        pad_done_q <= 1'b1;
      end else if (rep_go) begin
        pad_cnt_q <= pad_cnt_q - 7'h01;
      end
      if (data_go) begin
        pc_q <= pc_q + PC_W'(1);
        last_par_q <= f_data;
      end else if ((state_q == ST_DR) && rx) begin
        pc_q <= pc_q + PC_W'(1);
      end
    end
  end

  // ----------------------------------------------------------------
  // Command sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      op_q <= OP_IDENT_WR;
      gate_q <= 1'b0;
      oldv_q <= 1'b0;
      sh_q <= '0;
      cnt_q <= 3'h0;
      ident_q <= '0;
      done_q <= 1'b0;
      lock_err_q <= 1'b0;
      range_err_q <= 1'b0;
      rd_par_q <= '0;
      rd_vld_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      lock_err_q <= 1'b0;
      rd_vld_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          cnt_q <= 3'h0;
          if (cmd_go) begin
            op_q <= cmd_op;
            oldv_q <= old_variant;
            sh_q <= cmd_ident;
            if (((cmd_op == OP_DATA_WR) && wr_block)
                || ((cmd_op == OP_DATA_RD) && rd_block)) begin
              lock_err_q <= 1'b1;
            end else begin
              gate_q <= 1'b1;
              case (cmd_op)
                OP_IDENT_WR: state_q <= ST_IDW;
                OP_IDENT_RD: state_q <= ST_IDR;
                OP_DATA_WR: state_q <= ST_DW;
                default: state_q <= ST_DR;
              endcase
            end
          end
        end
        ST_IDW: begin
          if (idw_go) begin
            sh_q <= {16'h0000, sh_q[IDENT_W-1:16]};
            cnt_q <= cnt_q + 3'h1;
          end else if (cnt_q == 3'h4 && slot) begin
            state_q <= ST_IDLE;
            gate_q <= 1'b0;
            done_q <= 1'b1;
          end
        end
        ST_IDR: begin
          if (rx) begin
            // Byte pair reassembly, lowest bytes shifted down first
            sh_q <= {lnk.d2a_par[7:0], lnk.d2a_par[15:8], sh_q[IDENT_W-1:16]};
            cnt_q <= cnt_q + 3'h1;
            if (cnt_q == 3'h3) begin
              ident_q <= {lnk.d2a_par[7:0], lnk.d2a_par[15:8], sh_q[IDENT_W-1:16]};
              state_q <= ST_IDLE;
              gate_q <= 1'b0;
              done_q <= 1'b1;
            end
          end
        end
        ST_DW: begin
          if ((pc_q == PC_W'(DATA_LEN)) && !in_pad && slot) begin
            state_q <= ST_IDLE;
            gate_q <= 1'b0;
            done_q <= 1'b1;
          end
        end
        ST_DR: begin
          rd_par_q <= lnk.d2a_par;
          rd_vld_q <= rx;
          if (rx && (pc_q == rd_total - PC_W'(1))) begin
            state_q <= ST_IDLE;
            gate_q <= 1'b0;
            done_q <= 1'b1;
          end
        end
        default: begin
          state_q <= ST_IDLE;
          gate_q <= 1'b0;
        end
      endcase
      range_err_q <= bad_range;
    end
  end

  // Busy and pad flags as registered views
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_q <= 1'b0;
      padding_q <= 1'b0;
    end else begin
      busy_q <= gate_q;
      padding_q <= in_pad;
    end
  end

  assign lnk.gate = gate_q;
  assign lnk.op = op_q;
  assign lnk.old_variant = oldv_q;
  assign lnk.a2d_par = par_q;
  assign lnk.a2d_vld = vld_q;

endmodule
`default_nettype wire

/* File: testbench/dpid_link_asserts.sv */
// Protocol checker for the parcel link between adapter and drive
`timescale 1ns/1ps
`default_nettype none
module dpid_link_asserts
  import dpid_pkg::*;
#(
  parameter int DATA_LEN = DATA_PARCELS,
  parameter int PAD_LEN = PAD_PARCELS
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Link
  input wire logic gate,
  input wire dpid_op_t op,
  input wire logic old_variant,
  input wire logic [PAR_W-1:0] a2d_par,
  input wire logic a2d_vld,
  input wire logic d2a_rdy,
  input wire logic [PAR_W-1:0] d2a_par,
  input wire logic d2a_vld
);
  logic [15:0] xfer_q;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // Parcels taken so far; cleared while the gate is low
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)
      xfer_q <= 16'h0000;
    else if (!gate)
      xfer_q <= 16'h0000;
    else if (a2d_vld && d2a_rdy)
      xfer_q <= xfer_q + 16'h0001;
  end

  hold_parcel_a: assert property (a2d_vld && !d2a_rdy |=> a2d_vld && $stable(a2d_par))
    else $error("parcel changed before it was taken");
  idle_quiet_a: assert property (!gate |-> !a2d_vld)
    else $error("parcel sent outside an operation");
  op_steady_a: assert property (gate && $past(gate) |-> $stable(op) && $stable(old_variant))
    else $error("operation changed while gated");
  reply_gated_a: assert property (d2a_vld |-> gate || $past(gate))
    else $error("drive parcel outside an operation");
  ident_reply_a: assert property ($rose(gate) && op == OP_IDENT_RD |-> ##[1:3] d2a_vld [*4] ##1 !d2a_vld)
    else $error("ident reply is not four parcels");
  ident_burst_a: assert property ($rose(a2d_vld) && op == OP_IDENT_WR |-> a2d_vld [*4] ##1 !a2d_vld)
    else $error("ident write burst is not four parcels");
  ident_count_a: assert property ($fell(gate) && $past(op) == OP_IDENT_WR |-> xfer_q == 16'h0004)
    else $error("ident write count wrong");
  data_count_a: assert property ($fell(gate) && $past(op) == OP_DATA_WR && xfer_q != 16'h0000
    |-> xfer_q == 16'(DATA_LEN) || xfer_q == 16'(DATA_LEN + PAD_LEN))
    else $error("data write count wrong");
endmodule
`default_nettype wire

/* File: testbench/tb_top.sv */
// Bench joining adapter and drive ends over the parcel link
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import dpid_pkg::*;
  localparam int DLEN = 32;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic cmd_go = 1'b0;
  dpid_op_t cmd_op = OP_IDENT_WR;
  logic [63:0] cmd_ident = 64'h0;
  logic old_variant = 1'b0, wr_lock_ovr = 1'b0, rd_lock_ovr = 1'b0;
  logic [15:0] in_data = 16'h0000, media_par = 16'h0000;
  logic in_valid = 1'b0, media_vld = 1'b0, phys_ready = 1'b1, stall_en = 1'b0;
  logic in_ready, rd_vld_q, busy_q, done_q, lock_err_q, range_err_q;
  logic padding_q, phys_stb_q, pad_seen = 1'b0;
  logic [63:0] phys_word_q;
  logic [7:0] phys_parity_q;
  int stb_n = 0;
  logic [15:0] rd_par_q;
  logic [63:0] ident_q;
  logic [71:0] ident_fields_q;
  logic [7:0] cyc = 8'h00;
  logic [15:0] sent[$], got[$];
  int fail_count = 0, comparisons = 0;

  // ----------------------------------------------------------------
  // Clock, far-side stalls and link monitor
  // ----------------------------------------------------------------
  always #50 sys_clk = ~sys_clk;
  // Head group stalls one cycle in eight so the buffer backs up
  always @(negedge sys_clk) begin
    cyc <= cyc + 8'h01;
    phys_ready <= !stall_en || (cyc[2:0] != 3'h0);
  end
  // Record data parcels crossing the link and parcels read back
  always @(posedge sys_clk) begin
    if (i_dpid_link_if.a2d_vld && i_dpid_link_if.d2a_rdy && i_dpid_link_if.op == OP_DATA_WR)
      sent.push_back(i_dpid_link_if.a2d_par);
    if (rd_vld_q)
      got.push_back(rd_par_q);
    if (padding_q)
      pad_seen = 1'b1;
    if (phys_stb_q)
      stb_n++;
  end

  dpid_link_if i_dpid_link_if (.sys_clk(sys_clk), .rst_n(rst_n));
  dpid_adapter #(.DATA_LEN(DLEN)) i_dpid_adapter (.sys_clk(sys_clk), .rst_n(rst_n),
    .cmd_go(cmd_go), .cmd_op(cmd_op), .cmd_ident(cmd_ident), .old_variant(old_variant),
    .wr_lock_ovr(wr_lock_ovr), .rd_lock_ovr(rd_lock_ovr), .in_data(in_data),
    .in_valid(in_valid), .in_ready(in_ready), .rd_par_q(rd_par_q), .rd_vld_q(rd_vld_q),
    .busy_q(busy_q), .done_q(done_q), .lock_err_q(lock_err_q), .range_err_q(range_err_q),
    .padding_q(padding_q), .ident_q(ident_q), .lnk(i_dpid_link_if.adapter));
  dpid_drive i_dpid_drive (.sys_clk(sys_clk), .rst_n(rst_n), .lnk(i_dpid_link_if.drive),
    .phys_ready(phys_ready), .phys_word_q(phys_word_q), .phys_parity_q(phys_parity_q),
    .phys_stb_q(phys_stb_q),
    .media_par(media_par), .media_vld(media_vld), .ident_fields_q(ident_fields_q));
  dpid_link_asserts #(.DATA_LEN(DLEN), .PAD_LEN(PAD_PARCELS)) i_dpid_link_asserts (
    .sys_clk(sys_clk), .rst_n(rst_n), .gate(i_dpid_link_if.gate), .op(i_dpid_link_if.op),
    .old_variant(i_dpid_link_if.old_variant), .a2d_par(i_dpid_link_if.a2d_par),
    .a2d_vld(i_dpid_link_if.a2d_vld), .d2a_rdy(i_dpid_link_if.d2a_rdy),
    .d2a_par(i_dpid_link_if.d2a_par), .d2a_vld(i_dpid_link_if.d2a_vld));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task chk(input string what, input logic [71:0] seen, input logic [71:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task test_done;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Starts a command at a falling edge; bounded wait for its answer
  task run(input dpid_op_t op, output logic le);
    int n;
    cmd_op = op;
    cmd_go = 1'b1;
    @(negedge sys_clk);
    cmd_go = 1'b0;
    n = 0;
    while (done_q !== 1'b1 && lock_err_q !== 1'b1 && n < 3000) begin
      @(negedge sys_clk);
      n++;
    end
    le = lock_err_q;
    if (n >= 3000)
      fail_count++;
    repeat (3) @(negedge sys_clk);
  endtask

  // Holds the word offered until the buffer takes it
  task push(input logic [15:0] v);
    in_data = v;
    in_valid = 1'b1;
    while (in_ready !== 1'b1) @(negedge sys_clk);
    @(negedge sys_clk);
  endtask

  function automatic logic [63:0] mk(input logic [11:0] cyl, input logic [1:0] lk,
                                     input logic [11:0] dp);
    return 64'h5A | (64'(cyl) << CYL_POS) | (64'(lk) << WLOCK_POS) | (64'h1 << HEAD_POS)
      | (64'(SECT_MAX) << SECT_POS) | (64'h1 << KHF_POS) | (64'(dp) << DEF_POS);
  endfunction

  // Expected head fields: bit h of each byte under head h, parity head on top
  function automatic logic [71:0] spread(input logic [63:0] id, input logic ov);
    logic [71:0] f;
    for (int h = 0; h < 8; h++)
      for (int k = 0; k < 8; k++)
        f[8*h+k] = id[8*k+h];
    for (int k = 0; k < 8; k++)
      f[64+k] = ov & ~^id[8*k+:8];
    return f;
  endfunction

  task ident_rt(input logic [63:0] id);
    logic le;
    cmd_ident = id;
    run(OP_IDENT_WR, le);
    chk("ident fields", ident_fields_q, spread(id, old_variant));
    run(OP_IDENT_RD, le);
    chk("ident read", ident_q, id);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task s_ident;
    old_variant = 1'b1;
    ident_rt(mk(CYL_MAX, 2'h0, DEF_NO_PAD));
    chk("range clear", range_err_q, 1'b0);
    old_variant = 1'b0;
  endtask

  task s_lock;
    logic le;
    ident_rt(mk(CYL_MAX + 12'h001, 2'h3, DEF_NO_PAD));
    chk("range flag", range_err_q, 1'b1);
    run(OP_DATA_WR, le);
    chk("write lock", le, 1'b1);
    run(OP_DATA_RD, le);
    chk("read lock", le, 1'b1);
    rd_lock_ovr = 1'b1;
    got.delete();
    fork
      run(OP_DATA_RD, le);
      begin
        repeat (4) @(negedge sys_clk);
        for (int i = 0; i < DLEN; i++) begin
          media_par = 16'hB000 + 16'(i);
          media_vld = 1'b1;
          @(negedge sys_clk);
          media_vld = 1'b0;
          media_par = ~media_par;
          @(negedge sys_clk);
        end
      end
    join
    chk("read override", le, 1'b0);
    chk("read count", got.size(), DLEN);
    for (int i = 0; i < DLEN; i++)
      chk("read data", got[i], 16'hB000 + 16'(i));
    rd_lock_ovr = 1'b0;
  endtask

  // Data write through a full buffer, pad start p, variant ov
  task s_pad(input logic [11:0] p, input logic ov);
    logic le;
    logic [15:0] rep, e;
    logic [63:0] w;
    int np, k;
    old_variant = ov;
    ident_rt(mk(12'h010, 2'h1, p));
    sent.delete();
    pad_seen = 1'b0;
    stb_n = 0;
    stall_en = 1'b1;
    for (int i = 0; i < 8; i++)
      push(16'hA000 + 16'(i));
    in_valid = 1'b0;
    chk("buffer full", in_ready, 1'b0);
    @(negedge sys_clk);
    fork
      run(OP_DATA_WR, le);
      begin
        for (int i = 8; i < DLEN; i++)
          push(16'hA000 + 16'(i));
        in_valid = 1'b0;
      end
    join
    stall_en = 1'b0;
    np = (p == DEF_NO_PAD) ? DLEN : DLEN + PAD_PARCELS;
    chk("write count", sent.size(), np);
    chk("pad flag", pad_seen, p != DEF_NO_PAD);
    chk("word strobes", stb_n, np / 4);
    // Last word on the heads: byte 0 rode in the upper half of the first parcel
    w = {sent[np-1][7:0], sent[np-1][15:8], sent[np-2][7:0], sent[np-2][15:8],
      sent[np-3][7:0], sent[np-3][15:8], sent[np-4][7:0], sent[np-4][15:8]};
    chk("head word", {phys_parity_q, phys_word_q}, spread(w, ov));
    k = 4 * int'(p);
    rep = ov ? ((k == 0) ? 16'h0000 : 16'hA000 + 16'(k - 1)) : 16'hA000 + 16'(k);
    for (int i = 0; i < np; i++) begin
      e = (np == DLEN || i < k) ? 16'hA000 + 16'(i) : (i < k + 72) ? rep : 16'hA000 + 16'(i - 72);
      chk("write data", sent[i], e);
    end
  endtask

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(negedge sys_clk);
    rst_n = 1'b1;
    @(negedge sys_clk);
    chk("ready after reset", in_ready, 1'b1);
    chk("idle after reset", {busy_q, done_q, lock_err_q}, 3'h0);
    s_ident;
    s_lock;
    wr_lock_ovr = 1'b1;
    s_pad(12'h007, 1'b0);
    s_pad(12'h000, 1'b1);
    s_pad(DEF_NO_PAD, 1'b0);
    test_done;
  end

  // Far longer than the whole sequence needs
  initial begin
    #2000000;
    fail_count++;
    test_done;
  end
endmodule
`default_nettype wire
